// *** hw/psp_defs.svh ***
// Register map, field positions, reset values and widths of the host port block
`ifndef PSP_DEFS_SVH
`define PSP_DEFS_SVH

// Register indices; byte address is four times the index
`define IDX_DATA_PORT        8'h08
`define IDX_CONTROL_PINS     8'h09
`define IDX_IRQ_STATUS       8'h0c
`define IDX_IRQ_MASK         8'h8c
`define IDX_DIR_STATUS       8'h89
`define IDX_ANALOG_CFG       8'h9f
`define IDX_SHIFT            2

// Fields of port_direction_and_slave_status
`define FLD_IN_BUF_FULL      7
`define FLD_OUT_BUF_FULL     6
`define FLD_IN_BUF_OVERFLOW  5
`define FLD_HOST_PORT_MODE   4
`define FLD_DIR_CS           2
`define FLD_DIR_WR           1
`define FLD_DIR_RD           0
`define DIR_RESET            3'h7

// Field of analog_pin_configuration that turns the control pins digital
`define FLD_ANALOG_DIGITAL   1
`define ANALOG_CFG_RESET     3'h0

// Interrupt status and mask layout
`define FLD_IRQ_HOST_PORT    0

// Pin and bus widths
`define CTL_PINS             3
`define DATA_PINS            8
`define SYNC_BITS            11
`define PADDR_W              12

`endif

// *** hw/psp_pkg.sv ***
// Types shared by the host port block
`default_nettype none
package psp_pkg;
	typedef logic [7:0] byte_t;
	typedef enum logic [1:0] {
		XFER_IDLE  = 2'b00,
		XFER_WRITE = 2'b01,
		XFER_READ  = 2'b10
	} xfer_t;
endpackage
`default_nettype wire

// *** hw/sync_two_stage.sv ***
// Two-flop synchroniser, one chain per bit
`default_nettype none
module sync_two_stage #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             reset_n,
	// Asynchronous in, synchronous out
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic first;
			logic next_first;
			logic next_second;
			always_comb begin
				next_first  = async_in[i];
				next_second = first;
			end
			always_ff @(posedge clk) begin
				if (!reset_n) begin
					first       <= 1'b1;
					sync_out[i] <= 1'b1;
				end else begin
					first       <= next_first;
					sync_out[i] <= next_second;
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// *** hw/parallel_slave_port_control.sv ***
// Parallel slave port control and status with APB register access
//
// The APB register port was left to the implementer.
`default_nettype none
`include "psp_defs.svh"
module parallel_slave_port_control
	import psp_pkg::*;
(
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   reset_n,
	// APB slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [`PADDR_W-1:0]    paddr,
	input  wire logic [31:0]            pwdata,
	output var  logic [31:0]            prdata,
	output var  logic                   pready,
	output var  logic                   pslverr,
	// Control pins: bit0 read strobe, bit1 write strobe, bit2 chip select
	input  wire logic [`CTL_PINS-1:0]   ctl_pin_in,
	output var  logic [`CTL_PINS-1:0]   ctl_pin_out,
	output var  logic [`CTL_PINS-1:0]   ctl_pin_oe_n,
	// Parallel data pins
	input  wire logic [`DATA_PINS-1:0]  data_pin_in,
	output var  logic [`DATA_PINS-1:0]  data_pin_out,
	output var  logic                   data_pin_oe_n,
	// Interrupt
	output var  logic                   irq
);
	logic [`SYNC_BITS-1:0] pins_sync;
	logic [`CTL_PINS-1:0]  ctl_sync;
	byte_t                 data_sync;

	// Strobes and data share one synchroniser so they stay aligned
	sync_two_stage #(.WIDTH(`SYNC_BITS)) u_sync (
		.clk      (clk),
		.reset_n  (reset_n),
		.async_in ({data_pin_in, ctl_pin_in}),
		.sync_out (pins_sync)
	);

	assign ctl_sync  = pins_sync[`CTL_PINS-1:0];
	assign data_sync = pins_sync[`SYNC_BITS-1:`CTL_PINS];

	// Register state
	logic [`CTL_PINS-1:0] dir;
	logic [`CTL_PINS-1:0] pin_latch;
	logic [2:0]           analog_select_field;
	logic                 host_port_mode_sel;
	logic                 in_buf_full;
	logic                 out_buf_full;
	logic                 in_buf_overflow;
	logic                 host_port_irq_flag;
	logic                 irq_mask;
	byte_t                in_latch;
	byte_t                out_latch;
	byte_t                write_hold;
	xfer_t                xfer;

	logic [`CTL_PINS-1:0] next_dir;
	logic [`CTL_PINS-1:0] next_pin_latch;
	logic [2:0]           next_analog_select_field;
	logic                 next_host_port_mode_sel;
	logic                 next_in_buf_full;
	logic                 next_out_buf_full;
	logic                 next_in_buf_overflow;
	logic                 next_host_port_irq_flag;
	logic                 next_irq_mask;
	byte_t                next_in_latch;
	byte_t                next_out_latch;
	byte_t                next_write_hold;
	xfer_t                next_xfer;
	logic [31:0]          next_prdata;
	logic                 next_pready;
	logic                 next_pslverr;
	logic [`CTL_PINS-1:0] next_ctl_pin_out;
	logic [`CTL_PINS-1:0] next_ctl_pin_oe_n;
	logic [`DATA_PINS-1:0] next_data_pin_out;
	logic                 next_data_pin_oe_n;
	logic                 next_irq;

	// Host side decode
	logic host_selected;
	logic host_writing;
	logic host_reading;
	logic write_done;
	logic read_start;
	logic read_done;
	logic pins_digital;
	logic [`CTL_PINS-1:0] pin_read;

	always_comb begin
		host_selected = host_port_mode_sel && !ctl_sync[`FLD_DIR_CS];
		host_writing  = host_selected && !ctl_sync[`FLD_DIR_WR];
		host_reading  = host_selected && !ctl_sync[`FLD_DIR_RD];
		write_done    = (xfer == XFER_WRITE) && !host_writing;
		read_start    = (xfer != XFER_READ) && host_reading;
		read_done     = (xfer == XFER_READ) && !host_reading;
		pins_digital  = analog_select_field[`FLD_ANALOG_DIGITAL];
	end

	// Pins read back as zero while analog, else pin level or own latch
	always_comb begin
		for (int b = 0; b < `CTL_PINS; b++) begin
			if (!pins_digital) begin
				pin_read[b] = 1'b0;
			end else if (dir[b] || host_port_mode_sel) begin
				pin_read[b] = ctl_sync[b];
			end else begin
				pin_read[b] = pin_latch[b];
			end
		end
	end

	// Host transfer tracking
	always_comb begin
		next_write_hold = write_hold;
		case (xfer)
			XFER_IDLE: begin
				if (host_writing) begin
					next_xfer = XFER_WRITE;
				end else if (host_reading) begin
					next_xfer = XFER_READ;
				end else begin
					next_xfer = XFER_IDLE;
				end
			end
			XFER_WRITE: begin
				next_xfer = host_writing ? XFER_WRITE : XFER_IDLE;
			end
			XFER_READ: begin
				next_xfer = host_reading ? XFER_READ : XFER_IDLE;
			end
			default: begin
				next_xfer = XFER_IDLE;
			end
		endcase
		// Keep sampling while the strobe is low; the last sample is the latched word
		if (host_writing) begin
			next_write_hold = data_sync;
		end
	end

	// APB access decode
	logic                  apb_setup;
	logic                  apb_access;
	logic                  apb_wr;
	logic                  apb_rd;
	logic [`PADDR_W-1:0]   idx_full;
	logic [7:0]            idx;
	logic                  idx_mapped;
	logic                  addr_aligned;

	always_comb begin
		apb_setup    = psel && !penable;
		apb_access   = psel && penable && pready;
		apb_wr       = apb_access && pwrite && !pslverr;
		apb_rd       = apb_access && !pwrite && !pslverr;
		idx_full     = paddr >> `IDX_SHIFT;
		idx          = idx_full[7:0];
		addr_aligned = (paddr[`IDX_SHIFT-1:0] == 2'h0) && (idx_full[`PADDR_W-1:8] == '0);
		case (idx)
			`IDX_DATA_PORT, `IDX_CONTROL_PINS, `IDX_IRQ_STATUS,
			`IDX_IRQ_MASK, `IDX_DIR_STATUS, `IDX_ANALOG_CFG: begin
				idx_mapped = addr_aligned;
			end
			default: begin
				idx_mapped = 1'b0;
			end
		endcase
	end

	// Read data is prepared in the setup cycle, answered in the first access cycle
	always_comb begin
		next_pready  = apb_setup;
		next_pslverr = apb_setup ? !idx_mapped : pslverr;
		next_prdata  = prdata;
		if (apb_setup) begin
			next_prdata = 32'h0;
			if (!pwrite && idx_mapped) begin
				case (idx)
					`IDX_DATA_PORT:    next_prdata[7:0] = in_latch;
					`IDX_CONTROL_PINS: next_prdata[`CTL_PINS-1:0] = pin_read;
					`IDX_IRQ_STATUS:   next_prdata[`FLD_IRQ_HOST_PORT] = host_port_irq_flag;
					`IDX_IRQ_MASK:     next_prdata[`FLD_IRQ_HOST_PORT] = irq_mask;
					`IDX_DIR_STATUS: begin
						next_prdata[`FLD_IN_BUF_FULL]     = in_buf_full;
						next_prdata[`FLD_OUT_BUF_FULL]    = out_buf_full;
						next_prdata[`FLD_IN_BUF_OVERFLOW] = in_buf_overflow;
						next_prdata[`FLD_HOST_PORT_MODE]  = host_port_mode_sel;
						next_prdata[`CTL_PINS-1:0]        = dir;
					end
					`IDX_ANALOG_CFG:   next_prdata[2:0] = analog_select_field;
					default:           next_prdata = 32'h0;
				endcase
			end
		end
	end

	// Software writes, host events and flag updates
	always_comb begin
		next_dir                 = dir;
		next_pin_latch           = pin_latch;
		next_analog_select_field = analog_select_field;
		next_host_port_mode_sel  = host_port_mode_sel;
		next_in_buf_full         = in_buf_full;
		next_out_buf_full        = out_buf_full;
		next_in_buf_overflow     = in_buf_overflow;
		next_host_port_irq_flag  = host_port_irq_flag;
		next_irq_mask            = irq_mask;
		next_in_latch            = in_latch;
		next_out_latch           = out_latch;

		if (apb_wr) begin
			case (idx)
				`IDX_DATA_PORT: begin
					next_out_latch = pwdata[7:0];
					// A write during a host read goes out at once but leaves the flag clear
					if (!host_reading) begin
						next_out_buf_full = 1'b1;
					end
				end
				`IDX_CONTROL_PINS: next_pin_latch = pwdata[`CTL_PINS-1:0];
				`IDX_IRQ_STATUS: begin
					if (pwdata[`FLD_IRQ_HOST_PORT]) begin
						next_host_port_irq_flag = 1'b0;
					end
				end
				`IDX_IRQ_MASK:   next_irq_mask = pwdata[`FLD_IRQ_HOST_PORT];
				`IDX_DIR_STATUS: begin
					next_in_buf_overflow    = pwdata[`FLD_IN_BUF_OVERFLOW];
					next_host_port_mode_sel = pwdata[`FLD_HOST_PORT_MODE];
					next_dir                = pwdata[`CTL_PINS-1:0];
				end
				`IDX_ANALOG_CFG: next_analog_select_field = pwdata[2:0];
				default: begin
				end
			endcase
		end

		if (apb_rd && idx == `IDX_DATA_PORT) begin
			next_in_buf_full = 1'b0;
		end

		// Host events come after software updates so a host set or clear beats a software one in the same cycle
		if (write_done) begin
			next_in_latch           = write_hold;
			next_in_buf_full        = 1'b1;
			next_host_port_irq_flag = 1'b1;
			if (in_buf_full) begin
				next_in_buf_overflow = 1'b1;
			end
		end
		if (read_start) begin
			next_out_buf_full = 1'b0;
		end
		if (read_done) begin
			next_host_port_irq_flag = 1'b1;
		end

		if (!host_port_mode_sel) begin
			next_in_buf_full  = 1'b0;
			next_out_buf_full = 1'b0;
		end
	end

	// Pin drivers and interrupt output
	always_comb begin
		for (int b = 0; b < `CTL_PINS; b++) begin
			// Slave-port mode forces the strobes to inputs whatever the direction bits say
			next_ctl_pin_oe_n[b] = next_dir[b] || next_host_port_mode_sel;
		end
		next_ctl_pin_out   = next_pin_latch;
		next_data_pin_out  = next_out_latch;
		next_data_pin_oe_n = !(host_reading && next_xfer == XFER_READ);
		next_irq           = next_host_port_irq_flag && next_irq_mask;
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			dir                 <= `DIR_RESET;
			pin_latch           <= '0;
			analog_select_field <= `ANALOG_CFG_RESET;
			host_port_mode_sel  <= 1'b0;
			in_buf_full         <= 1'b0;
			out_buf_full        <= 1'b0;
			in_buf_overflow     <= 1'b0;
			host_port_irq_flag  <= 1'b0;
			irq_mask            <= 1'b0;
			in_latch            <= 8'h00;
			out_latch           <= 8'h00;
			write_hold          <= 8'h00;
			xfer                <= XFER_IDLE;
			prdata              <= 32'h0;
			pready              <= 1'b0;
			pslverr             <= 1'b0;
			ctl_pin_out         <= '0;
			ctl_pin_oe_n        <= '1;
			data_pin_out        <= 8'h00;
			data_pin_oe_n       <= 1'b1;
			irq                 <= 1'b0;
		end else begin
			dir                 <= next_dir;
			pin_latch           <= next_pin_latch;
			analog_select_field <= next_analog_select_field;
			host_port_mode_sel  <= next_host_port_mode_sel;
			in_buf_full         <= next_in_buf_full;
			out_buf_full        <= next_out_buf_full;
			in_buf_overflow     <= next_in_buf_overflow;
			host_port_irq_flag  <= next_host_port_irq_flag;
			irq_mask            <= next_irq_mask;
			in_latch            <= next_in_latch;
			out_latch           <= next_out_latch;
			write_hold          <= next_write_hold;
			xfer                <= next_xfer;
			prdata              <= next_prdata;
			pready              <= next_pready;
			pslverr             <= next_pslverr;
			ctl_pin_out         <= next_ctl_pin_out;
			ctl_pin_oe_n        <= next_ctl_pin_oe_n;
			data_pin_out        <= next_data_pin_out;
			data_pin_oe_n       <= next_data_pin_oe_n;
			irq                 <= next_irq;
		end
	end
endmodule
`default_nettype wire

// *** verification/psp_ctl_props.sv ***
// Port-level assertions for the host port control block
`default_nettype none
`include "psp_defs.svh"
module psp_ctl_props (
	input wire logic                  clk,
	input wire logic                  reset_n,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [`PADDR_W-1:0]   paddr,
	input wire logic [31:0]           pwdata,
	input wire logic [31:0]           prdata,
	input wire logic                  pready,
	input wire logic                  pslverr,
	input wire logic [`CTL_PINS-1:0]  ctl_pin_in,
	input wire logic [`CTL_PINS-1:0]  ctl_pin_out,
	input wire logic [`CTL_PINS-1:0]  ctl_pin_oe_n,
	input wire logic [`DATA_PINS-1:0] data_pin_in,
	input wire logic [`DATA_PINS-1:0] data_pin_out,
	input wire logic                  data_pin_oe_n,
	input wire logic                  irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	ready_after_setup_a: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held too long");
	ready_in_access_a: assert property (pready |-> psel && penable)
		else $error("pready outside access phase");
	misaligned_err_a: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
		else $error("misaligned access not refused");
	upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	read_drive_a: assert property ($fell(data_pin_oe_n) |-> !$past(ctl_pin_in[0], 2) && !$past(ctl_pin_in[2], 2))
		else $error("data driven without selected read");
	read_release_a: assert property ($rose(data_pin_oe_n) |-> $past(ctl_pin_in[0], 2) || $past(ctl_pin_in[2], 2))
		else $error("data released during read");
	deselect_idle_a: assert property (ctl_pin_in[2] [*4] |=> data_pin_oe_n)
		else $error("data driven while deselected");
	slave_pins_in_a: assert property (!data_pin_oe_n |-> ctl_pin_oe_n == 3'h7)
		else $error("control pin driven in slave mode");
endmodule
bind parallel_slave_port_control psp_ctl_props psp_ctl_props_i (.clk, .reset_n, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .ctl_pin_in, .ctl_pin_out, .ctl_pin_oe_n,
	.data_pin_in, .data_pin_out, .data_pin_oe_n, .irq);
`default_nettype wire

// *** verification/host_bus_model.sv ***
// External processor model on the strobe and data pins
`default_nettype none
`include "psp_defs.svh"
module host_bus_model (
	input  wire logic                  clk,
	input  wire logic [`CTL_PINS-1:0]  ctl_pin_out,
	input  wire logic [`CTL_PINS-1:0]  ctl_pin_oe_n,
	input  wire logic [`DATA_PINS-1:0] data_pin_out,
	input  wire logic                  data_pin_oe_n,
	output wire logic [`CTL_PINS-1:0]  ctl_pin_in,
	output wire logic [`DATA_PINS-1:0] data_pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] strobe = 3'h7;
	logic [7:0] drv    = 8'h00;
	logic       drv_en = 1'b0;
	assign ctl_pin_in = (strobe & ctl_pin_oe_n) | (ctl_pin_out & ~ctl_pin_oe_n);
	// Released bus shows inverted data so a stale sample cannot match
	assign data_pin_in = !data_pin_oe_n ? data_pin_out : (drv_en ? drv : ~drv);
	task automatic wr_byte(input logic cs, input logic [7:0] d);
		@(posedge clk);
		drv <= d;
		drv_en <= 1'b1;
		strobe <= {cs, 2'b01};
		repeat (4) @(posedge clk);
		strobe <= 3'h7;
		repeat (2) @(posedge clk);
		drv_en <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	// Flags a read that never saw the data bus driven, so the bench can stop
	task automatic rd_byte(output logic [7:0] d, output logic tmo);
		int n;
		@(posedge clk);
		strobe <= 3'b010;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (data_pin_oe_n !== 1'b0 && n < 16);
		d = data_pin_in;
		tmo = (data_pin_oe_n !== 1'b0);
		strobe <= 3'h7;
		repeat (6) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// *** verification/parallel_slave_port_control_tb.sv ***
// Self-checking bench for the host port control block
`default_nettype none
`include "psp_defs.svh"
module parallel_slave_port_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic            clk;
	logic            reset_n;
	logic            psel;
	logic            penable;
	logic            pwrite;
	logic            pready;
	logic            pslverr;
	logic            data_pin_oe_n;
	logic            irq;
	logic            e;
	logic            tmo;
	logic [11:0]     paddr;
	logic [31:0]     pwdata;
	logic [31:0]     prdata;
	logic [31:0]     q;
	logic [2:0]      ctl_pin_out;
	logic [2:0]      ctl_pin_oe_n;
	logic [7:0]      data_pin_out;
	logic [7:0]      got;
	wire logic [2:0] ctl_pin_in;
	wire logic [7:0] data_pin_in;
	int              num_errors = 0;
	int              compares = 0;
	parallel_slave_port_control parallel_slave_port_control_i (.clk, .reset_n, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .ctl_pin_in, .ctl_pin_out, .ctl_pin_oe_n,
		.data_pin_in, .data_pin_out, .data_pin_oe_n, .irq);
	host_bus_model host_bus_model_i (.clk, .ctl_pin_out, .ctl_pin_oe_n, .data_pin_out, .data_pin_oe_n,
		.ctl_pin_in, .data_pin_in);
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		compares++;
		if (g !== x) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, x, g);
		end
	endtask
	task automatic conclude;
		$display("Comparisons %0d, mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 16) begin
			num_errors++;
			conclude();
		end
	endtask
	task automatic rd(input logic [7:0] i, input logic [7:0] x);
		apb(1'b0, {2'h0, i, 2'h0}, 8'h00);
		chk($sformatf("reg %h", i), {24'h0, x}, q);
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		apb(1'b1, {2'h0, i, 2'h0}, d);
	endtask
	initial begin
		reset_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		rd(`IDX_DIR_STATUS, 8'h07);
		rd(`IDX_ANALOG_CFG, 8'h00);
		rd(`IDX_IRQ_MASK, 8'h00);
		rd(`IDX_CONTROL_PINS, 8'h00);
		wr(`IDX_ANALOG_CFG, 8'h02);
		rd(`IDX_CONTROL_PINS, 8'h07);
		wr(`IDX_CONTROL_PINS, 8'h04);
		wr(`IDX_DIR_STATUS, 8'h02);
		rd(`IDX_CONTROL_PINS, 8'h06);
		chk("ctl_pin_oe_n", 32'h2, {29'h0, ctl_pin_oe_n});
		chk("ctl_pin_out", 32'h4, {29'h0, ctl_pin_out});
		wr(`IDX_DIR_STATUS, 8'h10);
		rd(`IDX_DIR_STATUS, 8'h10);
		chk("ctl_pin_oe_n", 32'h7, {29'h0, ctl_pin_oe_n});
		$display("test pins done");
		wr(`IDX_DIR_STATUS, 8'h17);
		host_bus_model_i.wr_byte(1'b1, 8'ha5);
		rd(`IDX_DIR_STATUS, 8'h17);
		host_bus_model_i.wr_byte(1'b0, 8'h3c);
		rd(`IDX_DIR_STATUS, 8'h97);
		rd(`IDX_IRQ_STATUS, 8'h01);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(`IDX_IRQ_MASK, 8'h01);
		rd(`IDX_IRQ_MASK, 8'h01);
		chk("irq", 32'h1, {31'h0, irq});
		rd(`IDX_DATA_PORT, 8'h3c);
		rd(`IDX_DIR_STATUS, 8'h17);
		wr(`IDX_IRQ_STATUS, 8'h01);
		rd(`IDX_IRQ_STATUS, 8'h00);
		chk("irq cleared", 32'h0, {31'h0, irq});
		$display("test host write done");
		host_bus_model_i.wr_byte(1'b0, 8'h11);
		host_bus_model_i.wr_byte(1'b0, 8'h5a);
		rd(`IDX_DIR_STATUS, 8'hb7);
		rd(`IDX_DATA_PORT, 8'h5a);
		rd(`IDX_DIR_STATUS, 8'h37);
		wr(`IDX_DATA_PORT, 8'hc3);
		rd(`IDX_DIR_STATUS, 8'h77);
		// Clear the flag left by the host writes so only the read end can set it
		wr(`IDX_IRQ_STATUS, 8'h01);
		rd(`IDX_IRQ_STATUS, 8'h00);
		host_bus_model_i.rd_byte(got, tmo);
		if (tmo) begin
			num_errors++;
			conclude();
		end
		chk("host read", 32'hc3, {24'h0, got});
		rd(`IDX_DIR_STATUS, 8'h37);
		rd(`IDX_IRQ_STATUS, 8'h01);
		chk("irq read end", 32'h1, {31'h0, irq});
		$display("test overflow and host read done");
		host_bus_model_i.wr_byte(1'b0, 8'h66);
		rd(`IDX_DIR_STATUS, 8'hb7);
		wr(`IDX_DIR_STATUS, 8'h27);
		rd(`IDX_DIR_STATUS, 8'h27);
		host_bus_model_i.wr_byte(1'b0, 8'h99);
		rd(`IDX_DIR_STATUS, 8'h27);
		wr(`IDX_DIR_STATUS, 8'h07);
		rd(`IDX_DIR_STATUS, 8'h07);
		apb(1'b0, 12'h025, 8'h00);
		chk("misaligned err", 32'h1, {31'h0, e});
		apb(1'b0, 12'h040, 8'h00);
		chk("unmapped err", 32'h1, {31'h0, e});
		chk("unmapped data", 32'h0, q);
		$display("test mode off and errors done");
		conclude();
	end
endmodule
`default_nettype wire
